// ### common/sgc_consts.vh
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
// =====================================
// Register offsets
`define SGC_OFS_CTRL4 8'h06
`define SGC_OFS_CTRL5 8'h07
`define SGC_OFS_TEST_A 8'h08
`define SGC_OFS_TEST_B 8'h09
`define SGC_OFS_TEST_C 8'h0A
`define SGC_OFS_STATUS 8'h0B
// =====================================
// Field positions
`define SGC_BIT_RSVD7 7
`define SGC_BIT_HALF_DPX 6
`define SGC_BIT_PAUSE_EN 5
`define SGC_BIT_SPEED_10 4
`define SGC_BIT_NULL_VID 3
`define SGC_THR_HI_MSB 2
// =====================================
// Reset values
`define SGC_RST_CTRL4_LOW 4'h0
`define SGC_RST_CTRL5 8'h63
`define SGC_RST_TEST_A 8'h4E
`define SGC_RST_TEST_B 8'h24
`define SGC_RST_TEST_C 8'h24
// =====================================
// Timing at 20 MHz
`define SGC_CLK_HZ 20000000
`define SGC_PERIOD_100_MS 67
`define SGC_PERIOD_10_MS 500
`define SGC_BYTES_PER_BLOCK 7'h40
`endif

// ### core/sgc_global_ctrl.v
`timescale 1ns/10ps
`include "sgc_consts.vh"
module sgc_global_ctrl #(
	parameter NUM_PORTS = 3,
	parameter PERIOD_100_CYC = `SGC_CLK_HZ / 1000 * `SGC_PERIOD_100_MS,
	parameter PERIOD_10_CYC = `SGC_CLK_HZ / 1000 * `SGC_PERIOD_10_MS
) (
	input wire clk_in,
	input wire rst_in,
	input wire duplex_strap_pin_in,
	input wire pause_strap_pin_in,
	input wire speed_strap_pin_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wr_data_in,
	input wire [NUM_PORTS-1:0] bcast_byte_in,
	input wire [NUM_PORTS-1:0] bcast_sof_in,
	input wire [11:0] rx_vid_in,
	input wire [11:0] port_vid_in,
	output reg [7:0] reg_rd_data_out,
	output reg reg_rd_valid_out,
	output reg mii_half_duplex_out,
	output reg mii_pause_en_out,
	output reg mii_speed_10_out,
	output reg null_vid_replace_out,
	output reg [11:0] vid_out_out,
	output reg [10:0] storm_threshold_out,
	output reg [NUM_PORTS-1:0] bcast_drop_out
);
	// =====================================
	// Control registers
	reg rsvd7_r;
	reg half_dpx_r;
	reg pause_en_r;
	reg speed_10_r;
	reg null_vid_r;
	reg [2:0] thr_hi_r;
	reg [7:0] thr_lo_r;
	reg strap_done_r;
	reg [7:0] ctrl4_rd;
	reg rd_sel_mem_r;
	reg [7:0] rd_reg_r;
	wire [7:0] mem_rd_data;
	wire [10:0] threshold;
	wire mem_wr;
	wire mem_hit;

	assign threshold = {thr_hi_r, thr_lo_r};
	assign mem_hit = (reg_addr_in == `SGC_OFS_TEST_A) ||
		(reg_addr_in == `SGC_OFS_TEST_B) ||
		(reg_addr_in == `SGC_OFS_TEST_C);
	assign mem_wr = reg_wr_in && mem_hit;

	always @* begin
		ctrl4_rd = {rsvd7_r, half_dpx_r, pause_en_r, speed_10_r,
			null_vid_r, thr_hi_r};
	end

	// Straps are caught on the first clock after release, not under reset
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			strap_done_r <= 1'b0;
			rsvd7_r <= 1'b0;
			half_dpx_r <= 1'b0;
			pause_en_r <= 1'b0;
			speed_10_r <= 1'b0;
			{null_vid_r, thr_hi_r} <= `SGC_RST_CTRL4_LOW;
			thr_lo_r <= `SGC_RST_CTRL5;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			half_dpx_r <= duplex_strap_pin_in;
			pause_en_r <= pause_strap_pin_in;
			speed_10_r <= speed_strap_pin_in;
		end else if (reg_wr_in) begin
			if (reg_addr_in == `SGC_OFS_CTRL4) begin
				rsvd7_r <= reg_wr_data_in[`SGC_BIT_RSVD7];
				half_dpx_r <= reg_wr_data_in[`SGC_BIT_HALF_DPX];
				pause_en_r <= reg_wr_data_in[`SGC_BIT_PAUSE_EN];
				speed_10_r <= reg_wr_data_in[`SGC_BIT_SPEED_10];
				null_vid_r <= reg_wr_data_in[`SGC_BIT_NULL_VID];
				thr_hi_r <= reg_wr_data_in[`SGC_THR_HI_MSB:0];
			end else if (reg_addr_in == `SGC_OFS_CTRL5) begin
				thr_lo_r <= reg_wr_data_in;
			end
		end
	end

	// =====================================
	// Factory test store
	sgc_reg_mem u_mem (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_en_in(mem_wr),
		.addr_in(reg_addr_in[1:0]),
		.wr_data_in(reg_wr_data_in),
		.rd_data_out(mem_rd_data)
	);

	// =====================================
	// Read path, two cycles so the memory read register lines up
	reg rd_pend_r;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_pend_r <= 1'b0;
			rd_sel_mem_r <= 1'b0;
			rd_reg_r <= 8'h00;
			reg_rd_data_out <= 8'h00;
			reg_rd_valid_out <= 1'b0;
		end else begin
			rd_pend_r <= reg_rd_in;
			rd_sel_mem_r <= mem_hit;
			if (reg_addr_in == `SGC_OFS_CTRL4)
				rd_reg_r <= ctrl4_rd;
			else if (reg_addr_in == `SGC_OFS_CTRL5)
				rd_reg_r <= thr_lo_r;
			else if (reg_addr_in == `SGC_OFS_STATUS)
				rd_reg_r <= {7'h00, |bcast_drop_out};
			else
				rd_reg_r <= 8'h00;
			reg_rd_valid_out <= rd_pend_r;
			if (rd_pend_r)
				reg_rd_data_out <= rd_sel_mem_r ? mem_rd_data : rd_reg_r;
		end
	end

	// =====================================
	// Period timer, length follows the MII speed
	reg [31:0] period_cnt_r;
	reg period_tick_r;
	wire [31:0] period_len;
	assign period_len = speed_10_r ? PERIOD_10_CYC : PERIOD_100_CYC;

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			period_cnt_r <= 32'h00000000;
			period_tick_r <= 1'b0;
		end else if (period_cnt_r + 32'h00000001 >= period_len) begin
			period_cnt_r <= 32'h00000000;
			period_tick_r <= 1'b1;
		end else begin
			period_cnt_r <= period_cnt_r + 32'h00000001;
			period_tick_r <= 1'b0;
		end
	end

	// =====================================
	// Per-port broadcast block counters
	// A partly filled block counts as a whole one, so short frames count
	reg [5:0] byte_cnt_r [0:NUM_PORTS-1];
	reg [11:0] blk_cnt_r [0:NUM_PORTS-1];
	integer p;
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (p = 0; p < NUM_PORTS; p = p + 1) begin
				byte_cnt_r[p] <= 6'h00;
				blk_cnt_r[p] <= 12'h000;
			end
			bcast_drop_out <= {NUM_PORTS{1'b0}};
		end else begin
			for (p = 0; p < NUM_PORTS; p = p + 1) begin
				if (period_tick_r) begin
					byte_cnt_r[p] <= 6'h00;
					blk_cnt_r[p] <= 12'h000;
					bcast_drop_out[p] <= 1'b0;
				end else begin
					if (bcast_sof_in[p])
						bcast_drop_out[p] <=
							(blk_cnt_r[p] >= {1'b0, threshold});
					// Each frame opens a fresh block
					if (bcast_byte_in[p] && !bcast_drop_out[p]) begin
						byte_cnt_r[p] <= (bcast_sof_in[p] ? 6'h00 :
							byte_cnt_r[p]) + 6'h01;
						if ((bcast_sof_in[p] || byte_cnt_r[p] == 6'h00) &&
							blk_cnt_r[p] != 12'hFFF)
							blk_cnt_r[p] <= blk_cnt_r[p] + 12'h001;
					end else if (bcast_sof_in[p]) begin
						byte_cnt_r[p] <= 6'h00;
					end
				end
			end
		end
	end

	// =====================================
	// Outputs
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mii_half_duplex_out <= 1'b0;
			mii_pause_en_out <= 1'b0;
			mii_speed_10_out <= 1'b0;
			null_vid_replace_out <= 1'b0;
			vid_out_out <= 12'h000;
			storm_threshold_out <= 11'h000;
		end else begin
			mii_half_duplex_out <= half_dpx_r;
			mii_pause_en_out <= pause_en_r;
			mii_speed_10_out <= speed_10_r;
			null_vid_replace_out <= null_vid_r;
			if (null_vid_r && rx_vid_in == 12'h000)
				vid_out_out <= port_vid_in;
			else
				vid_out_out <= rx_vid_in;
			storm_threshold_out <= threshold;
		end
	end
endmodule

// ### core/sgc_reg_mem.v
`timescale 1ns/10ps
// =====================================
// Factory test register store, registered read data
module sgc_reg_mem (
	input wire clk_in,
	input wire rst_in,
	input wire wr_en_in,
	input wire [1:0] addr_in,
	input wire [7:0] wr_data_in,
	output reg [7:0] rd_data_out
);
`include "sgc_consts.vh"
	reg [7:0] test_a_r;
	reg [7:0] test_b_r;
	reg [7:0] test_c_r;

	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			test_a_r <= `SGC_RST_TEST_A;
			test_b_r <= `SGC_RST_TEST_B;
			test_c_r <= `SGC_RST_TEST_C;
			rd_data_out <= 8'h00;
		end else begin
			if (wr_en_in && addr_in == 2'h0)
				test_a_r <= wr_data_in;
			if (wr_en_in && addr_in == 2'h1)
				test_b_r <= wr_data_in;
			if (wr_en_in && addr_in == 2'h2)
				test_c_r <= wr_data_in;
			if (addr_in == 2'h0)
				rd_data_out <= test_a_r;
			else if (addr_in == 2'h1)
				rd_data_out <= test_b_r;
			else if (addr_in == 2'h2)
				rd_data_out <= test_c_r;
			else
				rd_data_out <= 8'h00;
		end
	end
endmodule

// ### sim/sgc_chk_sva.sv
`timescale 1ns/10ps
// =====================================
// Port checks for the global control block
module sgc_chk #(
	parameter NUM_PORTS = 3
) (
	input wire clk_in,
	input wire rst_in,
	input wire duplex_strap_pin_in,
	input wire pause_strap_pin_in,
	input wire speed_strap_pin_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [7:0] reg_addr_in,
	input wire [7:0] reg_wr_data_in,
	input wire [NUM_PORTS-1:0] bcast_byte_in,
	input wire [NUM_PORTS-1:0] bcast_sof_in,
	input wire [11:0] rx_vid_in,
	input wire [11:0] port_vid_in,
	input wire [7:0] reg_rd_data_out,
	input wire reg_rd_valid_out,
	input wire mii_half_duplex_out,
	input wire mii_pause_en_out,
	input wire mii_speed_10_out,
	input wire null_vid_replace_out,
	input wire [11:0] vid_out_out,
	input wire [10:0] storm_threshold_out,
	input wire [NUM_PORTS-1:0] bcast_drop_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// Third edge after release: strap capture has landed by then
	sequence s_rel;
		$past(rst_in, 3) && !$past(rst_in, 2);
	endsequence
	a_rd_answer: assert property (reg_rd_in |-> ##[2:3] reg_rd_valid_out)
		else $error("read not answered");
	a_valid_cause: assert property (reg_rd_valid_out |->
		$past(reg_rd_in, 2) || $past(reg_rd_in, 3))
		else $error("read answer without request");
	a_strap_duplex: assert property (s_rel |->
		mii_half_duplex_out == $past(duplex_strap_pin_in, 2))
		else $error("duplex strap not captured");
	a_strap_pause: assert property (s_rel |->
		mii_pause_en_out == $past(pause_strap_pin_in, 2))
		else $error("pause strap not captured");
	a_strap_speed: assert property (s_rel |->
		mii_speed_10_out == $past(speed_strap_pin_in, 2))
		else $error("speed strap not captured");
	a_thr_default: assert property (s_rel |->
		storm_threshold_out == 11'h063 && !null_vid_replace_out)
		else $error("threshold reset value wrong");
	a_vid_path: assert property (1'b1 |=> vid_out_out ==
		((null_vid_replace_out && $past(rx_vid_in) == 12'h000)
		? $past(port_vid_in) : $past(rx_vid_in)))
		else $error("vid output wrong");
	a_thr_hold: assert property (!$past(reg_wr_in) && !$past(reg_wr_in, 2)
		&& !$past(rst_in, 4) |-> $stable(storm_threshold_out))
		else $error("threshold moved without write");
	c_read: cover property (reg_rd_valid_out);
	c_wr_ctrl4: cover property (reg_wr_in && reg_addr_in == 8'h06);
	c_vid_sub: cover property (null_vid_replace_out && rx_vid_in == 12'h000);
	c_storm_drop: cover property (bcast_drop_out != 0);
endmodule
bind sgc_global_ctrl sgc_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// ### sim/tb.sv
`timescale 1ns/10ps
`include "sgc_consts.vh"
// =====================================
// Register bank bench
module tb;
	logic clk_in = 0;
	logic rst_in = 1;
	logic rd = 0;
	logic wr = 0;
	logic [2:0] strap = 3'b101;
	logic [7:0] addr = 0;
	logic [7:0] wd = 0;
	logic [7:0] rdata;
	logic [11:0] rx_vid = 0;
	logic [11:0] port_vid = 0;
	logic [11:0] vid;
	logic [2:0] sof = 0;
	logic [2:0] byt = 0;
	logic valid, half, pause, spd, nullr;
	logic [10:0] thr;
	logic [2:0] drop;
	int errors = 0;
	int comparisons = 0;
	always #25 clk_in = ~clk_in;
	// Short sim periods keep a whole storm period inside the run budget
	sgc_global_ctrl #(.PERIOD_100_CYC(200), .PERIOD_10_CYC(2000)) dut (
		.clk_in(clk_in), .rst_in(rst_in),
		.duplex_strap_pin_in(strap[2]), .pause_strap_pin_in(strap[1]),
		.speed_strap_pin_in(strap[0]), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_addr_in(addr), .reg_wr_data_in(wd), .bcast_byte_in(byt),
		.bcast_sof_in(sof), .rx_vid_in(rx_vid), .port_vid_in(port_vid),
		.reg_rd_data_out(rdata), .reg_rd_valid_out(valid),
		.mii_half_duplex_out(half), .mii_pause_en_out(pause),
		.mii_speed_10_out(spd), .null_vid_replace_out(nullr),
		.vid_out_out(vid), .storm_threshold_out(thr),
		.bcast_drop_out(drop));
	task automatic chk(string n, logic [11:0] e, logic [11:0] g);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(negedge clk_in);
		wr = 1;
		addr = a;
		wd = d;
		@(negedge clk_in);
		wr = 0;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [7:0] e);
		int i;
		@(negedge clk_in);
		rd = 1;
		addr = a;
		@(negedge clk_in);
		rd = 0;
		for (i = 0; i < 4 && valid !== 1'b1; i++) @(posedge clk_in) #1;
		chk("rd_valid", 12'h001, {11'h0, valid});
		chk("rd_data", {4'h0, e}, {4'h0, rdata});
	endtask
	task automatic summarize;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		summarize;
	end
	initial begin
		repeat (20) @(negedge clk_in);
		rst_in = 0;
		repeat (3) @(negedge clk_in);
		chk("straps", 12'h005, {9'h0, half, pause, spd});
		chk("thr_rst", 12'h063, {1'b0, thr});
		rd_chk(`SGC_OFS_CTRL4, 8'h50);
		rd_chk(`SGC_OFS_CTRL5, `SGC_RST_CTRL5);
		rd_chk(`SGC_OFS_TEST_A, `SGC_RST_TEST_A);
		rd_chk(`SGC_OFS_TEST_B, `SGC_RST_TEST_B);
		rd_chk(`SGC_OFS_TEST_C, `SGC_RST_TEST_C);
		rd_chk(8'h05, 8'h00);
		wr_reg(`SGC_OFS_CTRL4, 8'hAF);
		wr_reg(`SGC_OFS_CTRL5, 8'h01);
		for (int k = 8; k < 11; k++) wr_reg(k[7:0], 8'hA0 + k[7:0]);
		wr_reg(8'h20, 8'hFF);
		port_vid = 12'h123;
		repeat (3) @(negedge clk_in);
		chk("ctl", 12'h005, {8'h0, half, pause, spd, nullr});
		chk("thr", 12'h701, {1'b0, thr});
		chk("vid", 12'h123, vid);
		rd_chk(`SGC_OFS_CTRL4, 8'hAF);
		for (int k = 8; k < 11; k++) rd_chk(k[7:0], 8'hA0 + k[7:0]);
		rd_chk(8'h20, 8'h00);
		wr_reg(`SGC_OFS_CTRL4, 8'h00);
		repeat (3) @(negedge clk_in);
		chk("vid_keep", 12'h000, vid);
		chk("thr_low", 12'h001, {1'b0, thr});
		rx_vid = 12'h005;
		repeat (2) @(negedge clk_in);
		chk("vid_pass", 12'h005, vid);
		// Start of a period, so the storm checks below have a known frame
		@(posedge clk_in iff dut.period_tick_r);
		@(negedge clk_in);
		sof = 3'b001;
		byt = 3'b001;
		@(negedge clk_in);
		byt = 3'b000;
		@(negedge clk_in);
		sof = 3'b000;
		chk("drop_set", 12'h001, {9'h0, drop});
		rd_chk(`SGC_OFS_STATUS, 8'h01);
		repeat (150) @(negedge clk_in);
		chk("drop_hold", 12'h001, {9'h0, drop});
		repeat (50) @(negedge clk_in);
		chk("drop_clr", 12'h000, {9'h0, drop});
		summarize;
	end
endmodule
